/* logic/tws_regs.vh */
`ifndef TWS_REGS_VH
`define TWS_REGS_VH
// ==========================================================
// register map: byte address is four times the index
// only the low 12 bits of the byte address are decoded
`define TWS_IDX_MODE_CTRL    16'hFFAA
`define TWS_ADDR_MODE_CTRL   12'hEA8
`define TWS_ADDR_SHIFT_DATA  12'hEAC
`define TWS_ADDR_STATUS      12'hEB0
`define TWS_ADDR_PORT_CTRL   12'hEB4
// ==========================================================
// mode control fields
`define TWS_MC_ENABLE_BIT    7
`define TWS_MC_RXONLY_BIT    2
`define TWS_MC_CLKSEL_HI     1
`define TWS_MC_CLKSEL_LO     0
`define TWS_MC_WMASK         8'h87
`define TWS_MC_RESET         8'h00
`define TWS_SD_RESET         8'h00
// ==========================================================
// clock select codes
`define TWS_CS_EXT           2'h0
`define TWS_CS_TIMER         2'h1
`define TWS_CS_DIV64         2'h2
`define TWS_CS_DIV128        2'h3
// ==========================================================
// status fields
`define TWS_ST_DONE_BIT      0
`define TWS_ST_BUSY_BIT      1
// ==========================================================
// port control fields
`define TWS_PC_DATA_LATCH    0
`define TWS_PC_CLK_LATCH     1
`define TWS_PC_RESET         8'h03
// ==========================================================
// timing
`define TWS_BITS_PER_XFER    4'h8
`define TWS_DIV64_HALF       7'h20
`define TWS_DIV128_HALF      7'h40
`endif

/* logic/tws_sync.v */
`timescale 1ns/10ps
// ==========================================================
// two-stage synchroniser for pin inputs
module tws_sync #(
	parameter WIDTH = 1
) (
	input  wire             sys_clk,
	input  wire             rst_b,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			meta_q <= {WIDTH{1'b1}};
			sync_q <= {WIDTH{1'b1}};
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule // tws_sync

/* logic/tws_clkgen.v */
`timescale 1ns/10ps
`include "tws_regs.vh"
// ==========================================================
// internal serial clock: fx/64 or fx/128 from sys_clk
module tws_clkgen (
	input  wire       sys_clk,
	input  wire       rst_b,
	input  wire       run,
	input  wire       div128,
	output reg        sck_q,
	output wire       fall_tick,
	output wire       rise_tick
);
	reg  [6:0] cnt_q;
	wire [6:0] half;
	wire       wrap;

	assign half      = div128 ? `TWS_DIV128_HALF : `TWS_DIV64_HALF;
	assign wrap      = run && (cnt_q == half - 7'h01);
	assign fall_tick = wrap && sck_q;
	assign rise_tick = wrap && !sck_q;

	// idle clock rests high so each transfer opens on a fall
	always @(posedge sys_clk) begin
		if (!rst_b || !run) begin
			cnt_q <= 7'h00;
			sck_q <= 1'b1;
		end else if (wrap) begin
			cnt_q <= 7'h00;
			sck_q <= ~sck_q;
		end else begin
			cnt_q <= cnt_q + 7'h01;
		end
	end
endmodule // tws_clkgen

/* logic/tws_serial.v */
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`include "tws_regs.vh"
module tws_serial (
	input  wire        sys_clk,
	input  wire        rst_b,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        sck_in,
	output wire        sck_out,
	output wire        sck_oe,
	input  wire        sda_in,
	output wire        sda_out,
	output wire        sda_oe,
	input  wire        eight_bit_timer_output,
	output reg         transfer_done_irq
);
	localparam ST_IDLE = 2'b01;
	localparam ST_BUSY = 2'b10;

	reg  [7:0] mode_q;
	reg  [7:0] shift_q;
	reg  [3:0] bitcnt_q;
	reg  [1:0] state_q;
	reg        done_q;
	reg  [7:0] port_q;
	reg        out_latch_q;
	reg        ext_sck_q;
	reg        tmr_q;
	reg        tmr_prev_q;
	reg        sample_q;

	wire       sck_s;
	wire       sda_s;
	wire       tmr_s;
	wire       int_sck;
	wire       int_fall;
	wire       int_rise;
	wire       enabled;
	wire       rx_only;
	wire [1:0] clk_sel;
	wire       internal_clk;
	wire       busy;
	wire       fall_ev;
	wire       rise_ev;
	wire       access;
	wire       last_fall;

	function sel_hit;
		input [11:0] a;
		input [11:0] target;
		begin
			sel_hit = (a == target);
		end
	endfunction

	// ======================================================
	// pin synchronisers
	tws_sync #(.WIDTH(3)) u_sync (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.async_in ({sck_in, sda_in, eight_bit_timer_output}),
		.sync_out ({sck_s, sda_s, tmr_s})
	);

	assign enabled = mode_q[`TWS_MC_ENABLE_BIT];
	assign rx_only = mode_q[`TWS_MC_RXONLY_BIT];
	assign clk_sel = mode_q[`TWS_MC_CLKSEL_HI:`TWS_MC_CLKSEL_LO];
	assign internal_clk = (clk_sel != `TWS_CS_EXT);
	assign busy = (state_q == ST_BUSY);

	// ======================================================
	// serial clock sources
	// divided clocks from fx
	tws_clkgen u_clkgen (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.run       (busy && clk_sel[1]),
		.div128    (clk_sel == `TWS_CS_DIV128),
		.sck_q     (int_sck),
		.fall_tick (int_fall),
		.rise_tick (int_rise)
	);

	// timer output rising edges toggle the clock; external pin follows slave
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			ext_sck_q <= 1'b1;
			tmr_q     <= 1'b1;
		end else begin
			ext_sck_q <= sck_s;
			if (!busy)
				tmr_q <= 1'b1;
			else if (tmr_s && !tmr_prev_q)
				tmr_q <= ~tmr_q;
		end
	end

	// reset matches the synchroniser so no false edge follows reset
	always @(posedge sys_clk) begin
		if (!rst_b)
			tmr_prev_q <= 1'b1;
		else
			tmr_prev_q <= tmr_s;
	end

	assign fall_ev = busy && (
		(clk_sel == `TWS_CS_EXT)   ? (ext_sck_q && !sck_s) :
		(clk_sel == `TWS_CS_TIMER) ? (tmr_q && tmr_s && !tmr_prev_q) :
		int_fall);
	assign rise_ev = busy && (
		(clk_sel == `TWS_CS_EXT)   ? (!ext_sck_q && sck_s) :
		(clk_sel == `TWS_CS_TIMER) ? (!tmr_q && tmr_s && !tmr_prev_q) :
		int_rise);

	// ======================================================
	// apb slave, zero wait states
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign access  = psel && penable;

	always @* begin
		prdata = 32'h0000_0000;
		if (sel_hit(paddr, `TWS_ADDR_MODE_CTRL))
			prdata[7:0] = mode_q;
		else if (sel_hit(paddr, `TWS_ADDR_SHIFT_DATA))
			prdata[7:0] = shift_q;
		else if (sel_hit(paddr, `TWS_ADDR_STATUS))
			prdata[1:0] = {busy, done_q};
		else if (sel_hit(paddr, `TWS_ADDR_PORT_CTRL))
			prdata[7:0] = port_q;
	end

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			mode_q <= `TWS_MC_RESET;
			port_q <= `TWS_PC_RESET;
		end else if (access && pwrite) begin
			if (sel_hit(paddr, `TWS_ADDR_MODE_CTRL))
				mode_q <= pwdata[7:0] & `TWS_MC_WMASK;
			if (sel_hit(paddr, `TWS_ADDR_PORT_CTRL))
				port_q <= pwdata[7:0];
		end
	end

	// ======================================================
	// shift engine
	assign last_fall = fall_ev && (bitcnt_q == `TWS_BITS_PER_XFER);

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			shift_q     <= `TWS_SD_RESET;
			bitcnt_q    <= 4'h0;
			state_q     <= ST_IDLE;
			done_q      <= 1'b0;
			out_latch_q <= 1'b1;
			sample_q    <= 1'b1;
			transfer_done_irq <= 1'b0;
		end else begin
			transfer_done_irq <= 1'b0;
			if (access && !pwrite && sel_hit(paddr, `TWS_ADDR_STATUS))
				done_q <= 1'b0;
			if (!enabled) begin
				state_q  <= ST_IDLE;
				bitcnt_q <= 4'h0;
				// a write now only loads data
				if (access && pwrite &&
				    sel_hit(paddr, `TWS_ADDR_SHIFT_DATA))
					shift_q <= pwdata[7:0];
			end else begin
				case (state_q)
				ST_IDLE: begin
					if (access && sel_hit(paddr, `TWS_ADDR_SHIFT_DATA)) begin
						if (pwrite && !rx_only) begin
							shift_q  <= pwdata[7:0];
							state_q  <= ST_BUSY;
							bitcnt_q <= 4'h0;
						end
						if (!pwrite && rx_only) begin
							state_q  <= ST_BUSY;
							bitcnt_q <= 4'h0;
						end
						if (pwrite && rx_only)
							shift_q <= pwdata[7:0];
					end
				end
				ST_BUSY: begin
					if (rise_ev)
						sample_q <= sda_s;
					if (fall_ev && !last_fall) begin
						// later falls shift, so the next bit sits at 6
						if (bitcnt_q != 4'h0) begin
							out_latch_q <= shift_q[6];
							shift_q <= {shift_q[6:0], sample_q};
						end else begin
							out_latch_q <= shift_q[7];
						end
						bitcnt_q <= bitcnt_q + 4'h1;
					end
					if (last_fall) begin
						shift_q  <= {shift_q[6:0], sample_q};
						state_q  <= ST_IDLE;
						bitcnt_q <= 4'h0;
						done_q   <= 1'b1;
						out_latch_q <= 1'b1;
						transfer_done_irq <= 1'b1;
					end
				end
				default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// ======================================================
	// open-drain pins; enable high means pulling low
	// latches control pins outside serial use
	// data driven only in tx/rx mode
	assign sda_out = 1'b0;
	assign sda_oe  = !port_q[`TWS_PC_DATA_LATCH] ||
		(enabled && busy && !rx_only && !out_latch_q);
	assign sck_out = 1'b0;
	assign sck_oe  = !port_q[`TWS_PC_CLK_LATCH] ||
		(enabled && busy && internal_clk &&
		 (clk_sel[1] ? !int_sck : !tmr_q));
endmodule // tws_serial

/* verif/tws_partner.sv */
`timescale 1ns/10ps
// ==========
// slave peripheral on the open-drain lines
module tws_partner (
	input  wire       sck,
	input  wire       sda,
	input  wire       load,
	input  wire [7:0] tx_byte,
	output reg        sda_pull = 1'b0,
	output reg  [7:0] rx_byte = 8'h00
);
	reg [7:0] sh_q = 8'hFF;
	always @(negedge sck) begin
		sda_pull <= ~sh_q[7];
	end
	// sample on rise, then let go of the line
	always @(posedge sck or posedge load) begin
		if (load) begin
			sh_q <= tx_byte;
		end else begin
			rx_byte <= {rx_byte[6:0], sda};
			sh_q <= {sh_q[6:0], 1'b1};
			// held long enough for the pin synchronisers
			#25 sda_pull <= 1'b0;
		end
	end
endmodule // tws_partner

/* verif/tws_serial_assertions.sv */
`timescale 1ns/10ps
// ==========
// port checks
module tws_serial_assertions (
	input wire        sys_clk,
	input wire        rst_b,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire        sck_oe,
	input wire        sda_oe,
	input wire        transfer_done_irq
);
	reg  [7:0] mode_q;
	reg  [7:0] cnt_q;
	wire       acc = psel && penable;
	wire       sd_hit = acc && paddr == 12'hEAC && mode_q[7] && mode_q[1];
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			mode_q <= 8'h00;
			cnt_q <= 8'h00;
		end else begin
			if (acc && pwrite && paddr == 12'hEA8)
				mode_q <= pwdata[7:0] & 8'h87;
			// saturates so a long idle never aliases a half period
			cnt_q <= $changed(sck_oe) ? 8'h01 : cnt_q + {7'h00, cnt_q != 8'hFF};
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	a_irq_width: assert property (transfer_done_irq |=> !transfer_done_irq)
		else $error("done pulse too wide");
	a_irq_idle: assert property (transfer_done_irq |-> !sck_oe)
		else $error("clock busy at done");
	a_rx_no_drive: assert property (mode_q[2] && $stable(mode_q) |-> !sda_oe)
		else $error("data driven in rx mode");
	a_stop_free: assert property ($fell(mode_q[7]) |->
		##[1:4] (!sck_oe && !sda_oe))
		else $error("pins held after disable");
	a_ext_slave: assert property (mode_q[7] && mode_q[1:0] == 2'h0 |-> !sck_oe)
		else $error("clock driven as slave");
	a_half_period: assert property ($fell(sck_oe) && mode_q[7] && mode_q[1] &&
		$stable(mode_q) |-> cnt_q == (mode_q[0] ? 8'h40 : 8'h20))
		else $error("bad half period");
	a_tx_start: assert property (sd_hit && pwrite && !mode_q[2] |->
		##[1:140] sck_oe)
		else $error("write did not start");
	a_rx_start: assert property (sd_hit && !pwrite && mode_q[2] |->
		##[1:140] sck_oe)
		else $error("read did not start");
endmodule // tws_serial_assertions
bind tws_serial tws_serial_assertions chk_u (.sys_clk(sys_clk),
	.rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .sck_oe(sck_oe), .sda_oe(sda_oe),
	.transfer_done_irq(transfer_done_irq));

/* verif/tws_serial_tb.sv */
`timescale 1ns/10ps
// ==========
// bench
module tws_serial_tb;
	reg         sys_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
	reg         pwrite = 1'b0, tmr = 1'b0, sck_pull = 1'b0, load = 1'b0;
	reg  [11:0] paddr = 12'h000;
	reg  [31:0] pwdata = 32'h00000000;
	reg  [7:0]  rd = 8'h00, tx = 8'hFF, irq_cnt = 8'h00, rd_q = 8'h00;
	reg  [1:0]  drv = 2'h0;
	integer     fail_count = 0, total_checks = 0, cyc = 0;
	wire [31:0] prdata;
	wire [7:0]  prx;
	wire        pready, pslverr, sck_oe, sda_oe, sda_pull, transfer_done_irq;
	// open-drain lines with pull-ups
	wire        sck_w = ~(sck_oe | sck_pull);
	wire        sda_w = ~(sda_oe | sda_pull);
	tws_serial dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck_w),
		.sck_out(), .sck_oe(sck_oe), .sda_in(sda_w), .sda_out(),
		.sda_oe(sda_oe), .eight_bit_timer_output(tmr),
		.transfer_done_irq(transfer_done_irq));
	tws_partner pt_u (.sck(sck_w), .sda(sda_w), .load(load), .tx_byte(tx),
		.sda_pull(sda_pull), .rx_byte(prx));
	task chk(input [7:0] got, input [7:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("[ERR] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task apb(input w, input [11:0] a, input [7:0] d);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= {24'h000000, d};
			@(posedge sys_clk);
			penable <= 1'b1;
			@(posedge sys_clk);
			while (pready !== 1'b1) @(posedge sys_clk);
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge sys_clk);
			rd = rd_q;
		end
	endtask
	// read data taken at the very edge that completes the access
	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1) rd_q <= prdata[7:0];
	end
	task rdc(input [11:0] a, input [7:0] e);
		begin
			apb(1'b0, a, 8'h00);
			chk(rd, e);
		end
	endtask
	task xfer(input [7:0] m, input [7:0] d, input [7:0] p);
		reg [7:0] e;
		integer h;
		begin
			// open-drain wire: both ends see the and of both bytes, or the partner byte alone in rx-only mode
			e = m[2] ? p : d & p;
			h = m[0] ? 64 : 32;
			tx <= p;
			load <= 1'b1;
			apb(1'b1, 12'hEA8, m);
			load <= 1'b0;
			apb(1'b1, 12'hEAC, d);
			if (m[2]) apb(1'b0, 12'hEAC, 8'h00);
			drv = (m[1:0] == 2'h0) ? 2'h1 : (m[1:0] == 2'h1) ? 2'h2 : 2'h0;
			cyc = 0;
			rd = irq_cnt;
			while (irq_cnt === rd && cyc < 3000) begin
				@(posedge sys_clk);
				cyc = cyc + 1;
			end
			drv = 2'h0;
			if (m[1]) chk({7'h00, cyc >= 15 * h && cyc <= 19 * h}, 8'h01);
			chk(prx, e);
			rdc(12'hEB0, 8'h01);
			rdc(12'hEB0, 8'h00);
			apb(1'b1, 12'hEA8, 8'h00);
			rdc(12'hEAC, e);
			$display("xfer mode %h done", m);
		end
	endtask
	task tally_and_finish;
		begin
			$display("checks %0d mismatches %0d", total_checks, fail_count);
			if (fail_count == 0 && total_checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	initial forever #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (transfer_done_irq === 1'b1) irq_cnt <= irq_cnt + 8'h01;
	end
	// external and timer clock sources; the clock rests high
	initial forever begin
		repeat (8) @(posedge sys_clk);
		if (drv[0] || sck_pull) sck_pull <= ~sck_pull;
		if (drv[1]) tmr <= ~tmr;
	end
	initial begin
		#100000;
		fail_count = fail_count + 1;
		tally_and_finish;
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		rdc(12'hEA8, 8'h00);
		rdc(12'hEAC, 8'h00);
		rdc(12'hEB4, 8'h03);
		rdc(12'hFF0, 8'h00);
		apb(1'b1, 12'hEA8, 8'hFF);
		rdc(12'hEA8, 8'h87);
		apb(1'b1, 12'hEA8, 8'h00);
		apb(1'b1, 12'hEB4, 8'h00);
		@(posedge sys_clk);
		chk({6'h00, sck_oe, sda_oe}, 8'h03);
		apb(1'b1, 12'hEB4, 8'h03);
		$display("registers done");
		apb(1'b1, 12'hEAC, 8'h5A);
		apb(1'b1, 12'hEA8, 8'h82);
		repeat (200) @(posedge sys_clk);
		chk(irq_cnt, 8'h00);
		rdc(12'hEAC, 8'h5A);
		apb(1'b1, 12'hEAC, 8'h0F);
		repeat (100) @(posedge sys_clk);
		apb(1'b1, 12'hEA8, 8'h00);
		repeat (200) @(posedge sys_clk);
		chk({6'h00, sck_oe, sda_oe}, 8'h00);
		chk(irq_cnt, 8'h00);
		$display("late enable and abort done");
		xfer(8'h82, 8'hA5, 8'hFF);
		xfer(8'h83, 8'h3C, 8'hF0);
		xfer(8'h86, 8'hFF, 8'h96);
		xfer(8'h80, 8'hC3, 8'h5F);
		xfer(8'h81, 8'h69, 8'hFF);
		tally_and_finish;
	end
endmodule // tws_serial_tb
